// *** hdl/hub_pkg.sv ***
// constants, types and register map of the receive-mode and forwarding hub
package hub_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int NUM_TX = 2;
  localparam int CSI_FRAME_BITS = 40;
  localparam int RAW_FRAME_BITS = 28;
  localparam logic [1:0] FRAME_MARKER = 2'h2;
  localparam logic [11:0] RAW10_PIX_MASK = 12'h3FF;
  // ---------------------------------------------------------------
  // register indexes (byte address = 4 * index, page in index [9:8])
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_BC_RATE = 8'h58;
  localparam logic [7:0] IDX_TX_CTRL = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;
  localparam logic [7:0] IDX_RX_SETUP = 8'h6D;
  localparam logic [7:0] IDX_VC_MAP = 8'h71;
  localparam logic [7:0] IDX_RAW_HDR = 8'h72;
  localparam logic [7:0] IDX_FWD_DEST = 8'h73;
  localparam logic [7:0] IDX_RATE_INFO = 8'h74;
  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BC_RATE = 8'h00;
  localparam logic [7:0] RST_VC_MAP = 8'hE4;
  localparam logic [7:0] RST_RAW_HDR = 8'h2A;
  localparam logic [7:0] RST_FWD_DEST = 8'h00;
  localparam logic [7:0] RST_TX_CTRL = 8'h00;
  localparam logic [2:0] BC_NONSYNC_CODE = 3'h2;
  localparam int SETUP_DIV_BIT = 2;
  localparam int TXC_REPLICATE_BIT = 0;
  localparam int STAT_OVR_LSB = 4;
  localparam int STAT_PERR_LSB = 8;
  // ---------------------------------------------------------------
  // rate multipliers (rate_info: [7:0] num, [9:8] den, [12:10] pclk,
  // [14:13] back channel)
  // ---------------------------------------------------------------
  localparam logic [7:0] LINE_MULT_SYNC = 8'hA0;
  localparam logic [7:0] LINE_MULT_ASYNC = 8'h50;
  localparam logic [2:0] PCLK_MULT_SYNC = 3'h4;
  localparam logic [2:0] PCLK_MULT_ASYNC = 3'h2;
  localparam logic [1:0] BC_MULT_SYNC = 2'h2;
  localparam logic [1:0] HF_NUM = 2'h2;
  localparam logic [1:0] HF_DEN = 2'h3;
  localparam logic [1:0] RAW10_DEN = 2'h2;
  // ---------------------------------------------------------------
  // bus answers and types
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_CSI, MODE_RAW12_LF, MODE_RAW12_HF, MODE_RAW10
  } mode_type;
  typedef struct packed {
    logic [1:0] vc;
    logic [5:0] dt;
    logic [23:0] data;
  } tx_pkt_type;
endpackage

// *** hdl/hub_rx_forward.sv ***
// receive-mode decode, channel remap and forwarding to two outputs
//
// Functional notes
// - per-port CSI-2 or RAW mode, register or strap
// - CSI-2 ports decode forty-bit frames
// - RAW ports decode twenty-eight-bit frames
// - any port routes to either output
// - CSI-2 ports remap incoming virtual channels
// - sync CSI-2: line 160x, pixel 4x, back 2x
// - non-sync: line 80x, pixel per divider
// - RAW output gets programmable channel and type
// - RAW12 high-frequency: line pclk*2/3*28
// - RAW12 low-frequency: line pclk*28
// - RAW10: line pclk/2*28
// - YUV types ride the RAW path
// - output is always CSI-2 packets
// - streams interleave by distinct channel number
// - second output adds bandwidth or replicates
// - frames carry video, I2C, diagnostics, parity
// - control bits flow every frame, not blanking
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module hub_rx_forward
  import hub_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // receive links and strap
  input wire logic [NUM_PORTS-1:0] rx_bit,
  input wire logic [NUM_PORTS-1:0] rx_bit_strobe,
  input wire logic [2:0] rx_input_mode_sel,
  // control channel out
  output logic [NUM_PORTS-1:0] ctrl_valid,
  output logic [4*NUM_PORTS-1:0] ctrl_bits,
  // transmit ports
  output logic [NUM_TX-1:0] tx_valid,
  input wire logic [NUM_TX-1:0] tx_ready,
  output tx_pkt_type tx_pkt0,
  output tx_pkt_type tx_pkt1
);
  // ---------------------------------------------------------------
  // pin synchronisers and strap capture
  // ---------------------------------------------------------------
  logic [NUM_PORTS-1:0] bit_s1_reg, bit_s2_reg, stb_s1_reg, stb_s2_reg;
  logic [NUM_PORTS-1:0] stb_d_reg, bit_edge;
  logic [2:0] strap_s1_reg, strap_s2_reg;
  logic [1:0] strap_cnt_reg;
  logic strap_load;
  always_ff @(posedge ref_clk) begin
    bit_s1_reg <= rx_bit;
    bit_s2_reg <= bit_s1_reg;
    stb_s1_reg <= rx_bit_strobe;
    stb_s2_reg <= stb_s1_reg;
    stb_d_reg <= stb_s2_reg;
    strap_s1_reg <= rx_input_mode_sel;
    strap_s2_reg <= strap_s1_reg;
  end
  assign bit_edge = stb_s2_reg & ~stb_d_reg;
  // strap is read once the synchroniser has filled after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strap_cnt_reg <= 2'h0;
    end else if (strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end
  assign strap_load = (strap_cnt_reg == 2'h2);
  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  logic aw_hold_reg, w_hold_reg;
  logic [9:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write, wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [7:0] bc_rate_reg, tx_ctrl_reg;
  logic [7:0] setup_reg [NUM_PORTS];
  logic [7:0] vc_map_reg [NUM_PORTS];
  logic [7:0] raw_hdr_reg [NUM_PORTS];
  logic [NUM_PORTS-1:0] dest_reg, locked_reg, ovr_reg, perr_reg;
  logic [NUM_PORTS-1:0] wr_setup, mode_chg;
  logic [14:0] rate_info [NUM_PORTS];
  logic nonsync;
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign nonsync = (bc_rate_reg[2:0] == BC_NONSYNC_CODE);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      waddr_reg <= 10'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // global registers live in page 0 only; per-port ones in every page
  always_comb begin
    wr_hit = (waddr_reg[7:0] == IDX_RX_SETUP) ||
      (waddr_reg[7:0] == IDX_VC_MAP) || (waddr_reg[7:0] == IDX_RAW_HDR) ||
      (waddr_reg[7:0] == IDX_FWD_DEST) ||
      (waddr_reg[7:0] == IDX_RATE_INFO);
    if (waddr_reg[9:8] == 2'h0) begin
      wr_hit = wr_hit || (waddr_reg[7:0] == IDX_BC_RATE) ||
        (waddr_reg[7:0] == IDX_TX_CTRL) || (waddr_reg[7:0] == IDX_STATUS);
    end
  end
  always_comb begin
    logic [1:0] pg;
    pg = s_axi_araddr[11:10];
    rd_hit = 1'b1;
    rd_word = 32'h00000000;
    case (s_axi_araddr[9:2])
      IDX_RX_SETUP: rd_word[7:0] = setup_reg[pg];
      IDX_VC_MAP: rd_word[7:0] = vc_map_reg[pg];
      IDX_RAW_HDR: rd_word[7:0] = raw_hdr_reg[pg];
      IDX_FWD_DEST: rd_word[0] = dest_reg[pg];
      IDX_RATE_INFO: rd_word[14:0] = rate_info[pg];
      IDX_BC_RATE: rd_word[7:0] = bc_rate_reg;
      IDX_TX_CTRL: rd_word[7:0] = tx_ctrl_reg;
      IDX_STATUS: rd_word[11:0] = {perr_reg, ovr_reg, locked_reg};
      default: rd_hit = 1'b0;
    endcase
    if (pg != 2'h0 && (s_axi_araddr[9:2] == IDX_BC_RATE ||
        s_axi_araddr[9:2] == IDX_TX_CTRL ||
        s_axi_araddr[9:2] == IDX_STATUS)) begin
      rd_hit = 1'b0;
      rd_word = 32'h00000000;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // a strap of 0 means non-synchronous CSI-2, so its rate code loads too
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bc_rate_reg <= RST_BC_RATE;
      tx_ctrl_reg <= RST_TX_CTRL;
    end else begin
      if (strap_load && strap_s2_reg == 3'h0) begin
        bc_rate_reg <= {5'h00, BC_NONSYNC_CODE};
      end
      if (do_write && wstrb_reg[0] && waddr_reg == {2'h0, IDX_BC_RATE}) begin
        bc_rate_reg <= wdata_reg[7:0];
      end
      if (do_write && wstrb_reg[0] && waddr_reg == {2'h0, IDX_TX_CTRL}) begin
        tx_ctrl_reg <= wdata_reg[7:0];
      end
    end
  end
  // ---------------------------------------------------------------
  // per-port setup, frame decode and item holding
  // ---------------------------------------------------------------
  logic [NUM_PORTS-1:0] frame_good, item_valid_reg, pop;
  tx_pkt_type item_reg [NUM_PORTS];
  logic [5:0] bits_seen_reg;
  logic prior_good_reg;
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [39:0] shift_reg, shift_next;
      logic [5:0] cnt_reg, last_bit;
      logic csi, video, good, bad, wr_here, stat_wr;
      mode_type mode;
      assign mode = mode_type'(setup_reg[p][1:0]);
      assign csi = (mode == MODE_CSI);
      assign last_bit = csi ? 6'(CSI_FRAME_BITS - 1) :
        6'(RAW_FRAME_BITS - 1);
      assign shift_next = {shift_reg[38:0], bit_s2_reg[p]};
      assign wr_here = do_write && wstrb_reg[0] && waddr_reg[9:8] == 2'(p);
      assign wr_setup[p] = wr_here && waddr_reg[7:0] == IDX_RX_SETUP;
      assign mode_chg[p] = (wr_setup[p] &&
        wdata_reg[1:0] != setup_reg[p][1:0]) || strap_load;
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          setup_reg[p] <= 8'h00;
          vc_map_reg[p] <= RST_VC_MAP;
          raw_hdr_reg[p] <= RST_RAW_HDR;
          dest_reg[p] <= RST_FWD_DEST[0];
        end else begin
          if (strap_load) begin
            setup_reg[p] <= {6'h00, strap_s2_reg[1:0]};
          end
          if (wr_setup[p]) begin
            setup_reg[p] <= wdata_reg[7:0];
          end
          if (wr_here && waddr_reg[7:0] == IDX_VC_MAP) begin
            vc_map_reg[p] <= wdata_reg[7:0];
          end
          if (wr_here && waddr_reg[7:0] == IDX_RAW_HDR) begin
            raw_hdr_reg[p] <= wdata_reg[7:0];
          end
          if (wr_here && waddr_reg[7:0] == IDX_FWD_DEST) begin
            dest_reg[p] <= wdata_reg[0];
          end
        end
      end
      // on a bad window the count holds, sliding one bit per strobe
      assign video = csi ? shift_next[37] : shift_next[25];
      always_comb begin
        good = 1'b0;
        bad = 1'b0;
        if (bit_edge[p] && cnt_reg == last_bit) begin
          if (csi) begin
            good = shift_next[39:38] == FRAME_MARKER && !(^shift_next);
          end else begin
            good = shift_next[27:26] == FRAME_MARKER &&
              !(^shift_next[27:0]);
          end
          bad = !good;
        end
      end
      assign frame_good[p] = good;
      always_ff @(posedge ref_clk) begin
        if (rst || mode_chg[p]) begin
          shift_reg <= 40'h0000000000;
          cnt_reg <= 6'h00;
          locked_reg[p] <= 1'b0;
        end else if (bit_edge[p]) begin
          shift_reg <= shift_next;
          if (good) begin
            cnt_reg <= 6'h00;
          end else if (cnt_reg != last_bit) begin
            cnt_reg <= cnt_reg + 6'h01;
          end
          locked_reg[p] <= good;
        end
      end
      // fields: marker, video flag, I2C, diagnostics, parity, payload
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          ctrl_valid[p] <= 1'b0;
          ctrl_bits[4*p +: 4] <= 4'h0;
        end else begin
          ctrl_valid[p] <= good;
          if (good) begin
            ctrl_bits[4*p +: 4] <= csi ? shift_next[36:33] :
              {1'b0, shift_next[23], 1'b0, shift_next[24]};
          end
        end
      end
      // YUV streams use the same packing; only the programmed type differs
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          item_valid_reg[p] <= 1'b0;
          item_reg[p] <= '0;
        end else if (good && video) begin
          item_valid_reg[p] <= 1'b1;
          if (csi) begin
            item_reg[p].vc <= vc_map_reg[p][2*shift_next[31:30] +: 2];
            item_reg[p].dt <= shift_next[29:24];
            item_reg[p].data <= shift_next[23:0];
          end else begin
            item_reg[p].vc <= raw_hdr_reg[p][7:6];
            item_reg[p].dt <= raw_hdr_reg[p][5:0];
            item_reg[p].data <= {10'h000, shift_next[13:12],
              mode == MODE_RAW10 ? shift_next[11:0] & RAW10_PIX_MASK :
              shift_next[11:0]};
          end
        end else if (pop[p]) begin
          item_valid_reg[p] <= 1'b0;
        end
      end
      // sticky flags: a new event wins over a write-one clear
      assign stat_wr = do_write && waddr_reg == {2'h0, IDX_STATUS};
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          ovr_reg[p] <= 1'b0;
          perr_reg[p] <= 1'b0;
        end else begin
          if (good && video && item_valid_reg[p] && !pop[p]) begin
            ovr_reg[p] <= 1'b1;
          end else if (stat_wr && wstrb_reg[0] &&
              wdata_reg[STAT_OVR_LSB + p]) begin
            ovr_reg[p] <= 1'b0;
          end
          if (bad) begin
            perr_reg[p] <= 1'b1;
          end else if (stat_wr && wstrb_reg[1] &&
              wdata_reg[STAT_PERR_LSB + p]) begin
            perr_reg[p] <= 1'b0;
          end
        end
      end
      // line, pixel and back-channel multipliers for this port's mode
      always_comb begin
        rate_info[p] = 15'h0000;
        case (mode)
          MODE_CSI: begin
            if (nonsync) begin
              rate_info[p] = {2'h0, setup_reg[p][SETUP_DIV_BIT] ?
                3'h1 : PCLK_MULT_ASYNC, 2'h1, LINE_MULT_ASYNC};
            end else begin
              rate_info[p] = {BC_MULT_SYNC, PCLK_MULT_SYNC, 2'h1,
                LINE_MULT_SYNC};
            end
          end
          MODE_RAW12_LF: rate_info[p] = {5'h00, 2'h1,
            8'(RAW_FRAME_BITS)};
          MODE_RAW12_HF: rate_info[p] = {5'h00, HF_DEN,
            8'(RAW_FRAME_BITS * HF_NUM)};
          MODE_RAW10: rate_info[p] = {5'h00, RAW10_DEN,
            8'(RAW_FRAME_BITS)};
          default: rate_info[p] = 15'h0000;
        endcase
      end
    end
  endgenerate
  // ---------------------------------------------------------------
  // forwarding to the two outputs
  // ---------------------------------------------------------------
  logic replicate;
  logic [NUM_TX-1:0] slot_free, load, gnt_ok;
  logic [1:0] gnt [NUM_TX];
  logic [1:0] rr_reg [NUM_TX];
  logic [NUM_PORTS-1:0] req [NUM_TX];
  assign replicate = tx_ctrl_reg[TXC_REPLICATE_BIT];
  assign req[0] = item_valid_reg & (~dest_reg | {NUM_PORTS{replicate}});
  assign req[1] = item_valid_reg & dest_reg & {NUM_PORTS{!replicate}};
  assign slot_free = ~tx_valid | tx_ready;
  assign load[0] = gnt_ok[0] && slot_free[0] &&
    (!replicate || slot_free[1]);
  assign load[1] = replicate ? load[0] : (gnt_ok[1] && slot_free[1]);
  always_comb begin
    pop = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if ((load[0] && gnt[0] == 2'(i)) ||
          (load[1] && !replicate && gnt[1] == 2'(i))) begin
        pop[i] = 1'b1;
      end
    end
  end
  genvar t;
  generate
    for (t = 0; t < NUM_TX; t++) begin : g_tx
      // round robin so one busy port cannot starve the others
      always_comb begin
        logic [1:0] k;
        gnt_ok[t] = 1'b0;
        gnt[t] = 2'h0;
        k = 2'h0;
        for (int o = NUM_PORTS; o >= 1; o--) begin
          k = rr_reg[t] + 2'(o);
          if (req[t][k]) begin
            gnt_ok[t] = 1'b1;
            gnt[t] = k;
          end
        end
      end
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          rr_reg[t] <= 2'h3;
        end else if (load[t] && !(replicate && t == 1)) begin
          rr_reg[t] <= gnt[t];
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_valid <= '0;
      tx_pkt0 <= '0;
      tx_pkt1 <= '0;
    end else begin
      if (load[0]) begin
        tx_valid[0] <= 1'b1;
        tx_pkt0 <= item_reg[gnt[0]];
      end else if (tx_ready[0]) begin
        tx_valid[0] <= 1'b0;
      end
      if (load[1]) begin
        tx_valid[1] <= 1'b1;
        tx_pkt1 <= item_reg[replicate ? gnt[0] : gnt[1]];
      end else if (tx_ready[1]) begin
        tx_valid[1] <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || mode_chg[0]) begin
      bits_seen_reg <= 6'h00;
      prior_good_reg <= 1'b0;
    end else if (bit_edge[0]) begin
      bits_seen_reg <= frame_good[0] ? 6'h00 : bits_seen_reg + 6'h01;
      prior_good_reg <= prior_good_reg | frame_good[0];
    end
  end
  // port 1 carries the raw stream; its decoder restarts on a mode change
  logic [5:0] bits_seen1_reg;
  always_ff @(posedge ref_clk) begin
    if (rst || mode_chg[1]) begin
      bits_seen1_reg <= 6'h00;
    end else if (bit_edge[1]) begin
      bits_seen1_reg <= frame_good[1] ? 6'h00 : bits_seen1_reg + 6'h01;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_mode_write: assert property (wr_setup[0] |=>
    setup_reg[0][1:0] == $past(wdata_reg[1:0]))
    else $error("port 0 mode not written");
  chk_csi_length: assert property (frame_good[0] && prior_good_reg &&
    g_port[0].csi |-> bits_seen_reg == 6'(CSI_FRAME_BITS - 1))
    else $error("csi frame length wrong");
  chk_raw_length: assert property (frame_good[1] &&
    !g_port[1].csi |-> bits_seen1_reg == 6'(RAW_FRAME_BITS - 1))
    else $error("raw frame length wrong");
  chk_vc_remap: assert property (frame_good[0] && g_port[0].video &&
    g_port[0].csi |=> item_reg[0].vc ==
    $past(vc_map_reg[0][2*g_port[0].shift_next[31:30] +: 2]))
    else $error("virtual channel not remapped");
  chk_raw_header: assert property (frame_good[1] && g_port[1].video &&
    !g_port[1].csi |=> item_valid_reg[1] &&
    {item_reg[1].vc, item_reg[1].dt} == $past(raw_hdr_reg[1]))
    else $error("raw header not programmed value");
  chk_sync_rates: assert property (!nonsync && g_port[0].csi |->
    rate_info[0] == {BC_MULT_SYNC, PCLK_MULT_SYNC, 2'h1, LINE_MULT_SYNC})
    else $error("sync rate multipliers wrong");
  chk_ctrl_flow: assert property (frame_good[1] |=> ctrl_valid[1])
    else $error("control bits dropped");
  chk_replica: assert property (replicate && load[0] |=>
    tx_valid[1] && tx_pkt1 == tx_pkt0)
    else $error("second output not a replica");
  chk_tx_hold: assert property (tx_valid[0] && !tx_ready[0] |=>
    tx_valid[0] && $stable(tx_pkt0))
    else $error("output packet changed before taken");
  chk_mode_isolate: assert property (mode_chg[1] && !mode_chg[0] |=>
    $stable(setup_reg[0]))
    else $error("other port mode disturbed");
  cov_csi_frame: cover property (frame_good[0] && g_port[0].csi);
  cov_raw_frame: cover property (frame_good[1] && !g_port[1].csi);
  cov_replicate: cover property (replicate && load[0] && load[1]);
  cov_overrun: cover property (ovr_reg[0]);
endmodule

// *** verif/link_source.sv ***
// partner model: remote serializers sending frames on the four links
`timescale 1ns/1ps
module link_source (
  // clock
  input wire logic ref_clk,
  // link pins
  output logic [3:0] bit_o,
  output logic [3:0] strb_o
);
  initial begin
    bit_o = 4'h0;
    strb_o = 4'h0;
  end
  // n is 40 or 28; strobe high and low two cycles each, bit set first
  task automatic send(input int p, input logic [39:0] f, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk);
      bit_o[p] <= f[i];
      strb_o[p] <= 1'b0;
      @(posedge ref_clk);
      @(posedge ref_clk);
      strb_o[p] <= 1'b1;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    strb_o[p] <= 1'b0;
    // idle line shows the inverse so a stale bit never looks valid
    bit_o[p] <= ~f[0];
  endtask
endmodule

// *** verif/sensor_hub_rx_mode_forwarding_tb.sv ***
// self-checking bench: register bus, link frames and forwarding
`timescale 1ns/1ps
module sensor_hub_rx_mode_forwarding_tb;
  import hub_pkg::*;
  logic ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, csi, raw;
  logic [3:0] s_axi_wstrb, rx_bit, rx_bit_strobe, ctrl_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, tx_valid, tx_ready, rr, br;
  logic [2:0] rx_input_mode_sel;
  logic [15:0] ctrl_bits;
  logic [39:0] f;
  tx_pkt_type tx_pkt0, tx_pkt1;
  int error_cnt = 0;
  int n_checks = 0;
  int n_ctrl = 0;
  hub_rx_forward dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_bit, .rx_bit_strobe,
    .rx_input_mode_sel, .ctrl_valid, .ctrl_bits, .tx_valid, .tx_ready,
    .tx_pkt0, .tx_pkt1);
  link_source src (.ref_clk(ref_clk), .bit_o(rx_bit), .strb_o(rx_bit_strobe));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // control pulses last one cycle, so they are counted as they pass
  always @(posedge ref_clk) n_ctrl += $countones(ctrl_valid);
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  function automatic logic [11:0] ad(input logic [1:0] p, logic [7:0] i);
    return {p, i, 2'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {rv, rr} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic got_tx(input int t, input logic [31:0] e);
    int k;
    k = 0;
    while (tx_valid[t] !== 1'b1 && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    chk({31'h0, tx_valid[t]}, 32'h1);
    chk(t ? tx_pkt1 : tx_pkt0, e);
    tx_ready[t] <= 1'b1;
    @(posedge ref_clk);
    tx_ready[t] <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
    {s_axi_arvalid, s_axi_rready, tx_ready} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    rx_input_mode_sel = 3'h4;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(ad(0, IDX_RX_SETUP)); chk(rv, 32'h0);
    rd(ad(0, IDX_RATE_INFO)); chk(rv, 32'h51A0);
    wr(ad(0, IDX_BC_RATE), 32'h2);
    chk({30'h0, br}, {30'h0, RESP_OKAY});
    wr(ad(0, IDX_RX_SETUP), 32'h4);
    rd(ad(0, IDX_RATE_INFO)); chk(rv, 32'h0550);
    wr(ad(0, IDX_RX_SETUP), 32'h0);
    rd(ad(0, IDX_RATE_INFO)); chk(rv, 32'h0950);
    wr(ad(1, IDX_RX_SETUP), 32'h3);
    rd(ad(1, IDX_RX_SETUP)); chk(rv, 32'h3);
    rd(ad(1, IDX_RATE_INFO)); chk(rv & 32'h3FF, 32'h21C);
    wr(ad(2, IDX_RX_SETUP), 32'h1);
    rd(ad(2, IDX_RATE_INFO));
    chk(rv, 32'h011C);
    wr(ad(3, IDX_RX_SETUP), 32'h2);
    rd(ad(3, IDX_RATE_INFO));
    chk(rv, 32'h0338);
    rd(ad(0, 8'h10)); chk({rv[29:0], rr}, {30'h0, RESP_SLVERR});
    wr(ad(0, 8'h10), 32'h0);
    chk({30'h0, br}, {30'h0, RESP_SLVERR});
    $display("test done: registers");
    wr(ad(0, IDX_VC_MAP), 32'hEC);
    wr(ad(1, IDX_RAW_HDR), 32'h9E);
    wr(ad(1, IDX_FWD_DEST), 32'h1);
    f = {8'hA8, 2'h1, 6'h1E, 24'hABCDEF};
    f[32] = ^f;
    csi = {2'h3, 6'h1E, 24'hABCDEF};
    src.send(0, f, CSI_FRAME_BITS);
    got_tx(0, csi);
    chk({28'h0, ctrl_bits[3:0]}, 32'h4);
    wr(ad(0, IDX_BC_RATE), {24'h0, RST_BC_RATE});
    f = {12'h0, 6'h2C, 8'h0, 2'h1, 12'hFFF};
    f[22] = ^f;
    raw = {2'h2, 6'h1E, 24'h0013FF};
    src.send(1, f, RAW_FRAME_BITS);
    got_tx(1, raw);
    chk({28'h0, ctrl_bits[7:4]}, 32'h1);
    rd(ad(0, IDX_STATUS));
    chk(rv, 32'h3);
    $display("test done: frames");
    wr(ad(0, IDX_TX_CTRL), 32'h1);
    f = {8'hA8, 2'h1, 6'h1E, 24'hABCDEF};
    f[32] = ^f;
    src.send(0, f, CSI_FRAME_BITS);
    got_tx(0, csi);
    got_tx(1, csi);
    chk(n_ctrl, 32'h3);
    $display("test done: replicate");
    end_sim;
  end
  initial begin
    #100us;
    error_cnt++;
    end_sim;
  end
endmodule
